//--- inc/rid_regs.vh
`ifndef RID_REGS_VH
`define RID_REGS_VH

// Register port map
`define RID_REG_OPT0        4'h0
`define RID_REG_OPT1        4'h1
`define RID_REG_CTRL        4'h2
`define RID_REG_PC          4'h3
`define RID_REG_ACC         4'h4
`define RID_CTRL_RUN        0
`define RID_CTRL_RESET      1'h1

// Option word zero fields
`define RID_OPT0_FREQ       1
`define RID_OPT0_OST_HI     3
`define RID_OPT0_OST_LO     2
`define RID_OPT0_ID_HI      12
`define RID_OPT0_ID_LO      4

// Option word one fields
`define RID_OPT1_PKG_HI     1
`define RID_OPT1_PKG_LO     0
`define RID_OPT1_PULLUP     4
`define RID_OPT1_ADRUN      5
`define RID_OPT1_EP2_ON     6
`define RID_OPT1_ENDPOINT_TWO_DIRECTION    7
`define RID_OPT1_EP2_MAX_HI 10
`define RID_OPT1_EP2_MAX_LO 8
`define RID_PKG_40          2'h1
`define RID_PKG_44          2'h3

// Status and bank select fields
`define RID_ST_C            0
`define RID_ST_DC           1
`define RID_ST_Z            2
`define RID_ST_P            3
`define RID_ST_T            4
`define RID_ST_PAGE_HI      7
`define RID_ST_PAGE_LO      5
`define RID_BANK_HI         7
`define RID_BANK_LO         6

// Operand addresses
`define RID_A_INDIRECT      6'h00
`define RID_A_TIMER         6'h01
`define RID_A_PC            6'h02
`define RID_A_STATUS        6'h03
`define RID_A_BANK          6'h04
`define RID_A_IO_FIRST      6'h05
`define RID_A_GPR_FIRST     6'h10

// Reset values
`define RID_IOC_RESET       8'hFF
`define RID_CONT_RESET      8'h3F
`define RID_STATUS_RESET    8'h18

// Start-up wait times
`define RID_CLK_MHZ         100
`define RID_OST0_US         500
`define RID_OST1_US         2000
`define RID_OST2_US         8000
`define RID_OST3_US         16000
`define RID_WAIT_W          21

`endif

//--- rtl/rid_core.v
// What this block does
// - each instruction is a 13-bit word split into opcode and operand fields
// - ordinary instructions take one instruction cycle of two clocks
// - counter writes, calls, returns, jumps, true skips take two cycles
// - the register field selects one of 64 registers
// - bank select bits 7 and 6 choose the addressed register bank
// - bit instructions set, clear or test any bit, 3-bit position
// - I/O registers are reached as ordinary registers
// - literal is 8 bits for immediates, 10 bits for call and jump
// - table add puts counter plus accumulator in counter, flags updated
// - return-and-reenable pops the counter and enables interrupts
// - decrement-skip writes operand minus one, skips on zero, no flags
// - I/O control read and write use only control registers, 4-bit select
// - option words are not reachable by executing code
// - option zero bit 1 picks 12 MHz (0) or 6 MHz (1)
// - option zero bits 3-2 pick 500us, 2ms, 8ms or 16ms start-up
// - option zero bits 12-4 are a user identity value only
// - option one bit 4 zero connects the D- pull-up switch
// - option one bit 5 zero halts the core during conversion
// - option one bit 6 enables endpoint two, bit 7 gives direction
// - option one bits 10-8 give endpoint two size as value plus one
// - option one bits 1-0 give package, 01 40-pin, 11 44-pin
`timescale 1ns/100ps
`include "rid_regs.vh"

module rid_core #(
  parameter WAIT0_CYCLES = `RID_OST0_US * `RID_CLK_MHZ,
  parameter WAIT1_CYCLES = `RID_OST1_US * `RID_CLK_MHZ,
  parameter WAIT2_CYCLES = `RID_OST2_US * `RID_CLK_MHZ,
  parameter WAIT3_CYCLES = `RID_OST3_US * `RID_CLK_MHZ
) (
  // Clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // Option words
  input  wire [12:0]  optWordZeroIn,
  input  wire [12:0]  optWordOneIn,
  // Program memory
  output reg  [12:0]  romAddr,
  input  wire [12:0]  instrWord,
  // I/O register port
  output reg  [3:0]   ioAddr,
  output reg          ioWrite,
  output reg  [7:0]   ioWdata,
  input  wire [7:0]   ioRdata,
  // Analog converter
  input  wire         adcBusy,
  // Core state
  output reg          coreRunning,
  output reg          irqEnable,
  output reg  [7:0]   contReg,
  output wire [127:0] ioControlFlat,
  output reg          wdtClear,
  output reg          sleepStart,
  // Option outputs
  output reg          coreSlowClock,
  output reg          pullUpConnect,
  output reg          endpointTwoOn,
  output reg          endpointTwoDirection,
  output reg  [3:0]   endpointTwoMaxBytes,
  output reg  [1:0]   packageCode,
  output reg          packageKnown,
  // Register port
  input  wire [3:0]   regAddr,
  input  wire [12:0]  regWdata,
  input  wire         regWrite,
  input  wire         regRead,
  output reg  [12:0]  regRdata
);

  reg  [12:0]           optWordZero;
  reg  [12:0]           optWordOne;
  reg                   optLoaded;
  reg  [`RID_WAIT_W-1:0] waitCnt;
  reg  [`RID_WAIT_W-1:0] waitLimit;
  reg                   runEnable;
  reg                   phase;
  reg                   bubble;
  reg  [12:0]           pc;
  reg  [7:0]            acc;
  reg  [7:0]            status;
  reg  [7:0]            bankSel;
  reg  [7:0]            timerReg;
  reg  [2:0]            sp;
  reg  [7:0]            gpr [0:255];
  reg  [12:0]           stack [0:7];
  reg  [7:0]            ioc [0:15];
  integer               i;

  wire        run;
  wire        exec;
  wire [12:0] pcPlus1;
  wire [7:0]  lit;

  reg  [5:0]  ea;
  reg  [7:0]  regVal;
  reg  [7:0]  bitMask;
  reg  [8:0]  sumR;
  reg  [8:0]  sumK;
  reg  [8:0]  diffR;
  reg  [8:0]  diffK;
  reg  [8:0]  daaTmp;
  reg  [7:0]  res;
  reg         wrR;
  reg         wrA;
  reg         updZ;
  reg         updC;
  reg         updDC;
  reg         cOut;
  reg         dcOut;
  reg         skipTaken;
  reg         jump;
  reg  [12:0] target;
  reg         push;
  reg         pop;
  reg         iocWr;
  reg         iocRd;
  reg         doEni;
  reg         doDisi;
  reg         doReti;
  reg         doCont;
  reg         doSleep;
  reg         doWdt;
  reg         pcWr;
  reg  [7:0]  next_status;
  reg  [12:0] next_pc;

  assign pcPlus1 = pc + 13'h0001;
  assign lit     = instrWord[7:0];
  assign run  = coreRunning && runEnable &&
                !(!optWordOne[`RID_OPT1_ADRUN] && adcBusy);
  assign exec = run && phase;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : gIoc
      assign ioControlFlat[g*8 +: 8] = ioc[g];
    end
  endgenerate

  // Operand selection and decode
  always @*
  begin
    ea = (instrWord[5:0] == `RID_A_INDIRECT) ? bankSel[5:0] : instrWord[5:0];
    if (ea >= `RID_A_GPR_FIRST)
      regVal = gpr[{bankSel[`RID_BANK_HI:`RID_BANK_LO], ea}];
    else
    begin
      case (ea)
        `RID_A_INDIRECT: regVal = 8'h00;
        `RID_A_TIMER:    regVal = timerReg;
        `RID_A_PC:       regVal = pcPlus1[7:0];
        `RID_A_STATUS:   regVal = status;
        `RID_A_BANK:     regVal = bankSel;
        default:         regVal = ioRdata;
      endcase
    end
    bitMask = 8'h01 << instrWord[8:6];
    sumR    = {1'b0, regVal} + {1'b0, acc};
    sumK    = {1'b0, lit} + {1'b0, acc};
    diffR   = {1'b0, regVal} - {1'b0, acc};
    diffK   = {1'b0, lit} - {1'b0, acc};
    daaTmp  = {1'b0, acc} +
              (((acc[3:0] > 4'h9) || status[`RID_ST_DC]) ? 9'h006 : 9'h000);
    res = 8'h00;     wrR = 1'b0;    wrA = 1'b0;
    updZ = 1'b0;     updC = 1'b0;   updDC = 1'b0;
    cOut = 1'b0;     dcOut = 1'b0;  skipTaken = 1'b0;
    jump = 1'b0;     push = 1'b0;   pop = 1'b0;
    iocWr = 1'b0;    iocRd = 1'b0;  doEni = 1'b0;
    doDisi = 1'b0;   doReti = 1'b0; doCont = 1'b0;
    doSleep = 1'b0;  doWdt = 1'b0;
    target = {status[`RID_ST_PAGE_HI:`RID_ST_PAGE_LO], instrWord[9:0]};
    casez (instrWord)
      13'b1_00??_????_????:
      begin
        push = 1'b1;
        jump = 1'b1;
      end
      13'b1_01??_????_????: jump = 1'b1;
      13'b1_1000_????_????:
      begin
        res = lit;
        wrA = 1'b1;
      end
      13'b1_1001_????_????:
      begin
        res = acc | lit;
        wrA = 1'b1;
        updZ = 1'b1;
      end
      13'b1_1010_????_????:
      begin
        res = acc & lit;
        wrA = 1'b1;
        updZ = 1'b1;
      end
      13'b1_1011_????_????:
      begin
        res = acc ^ lit;
        wrA = 1'b1;
        updZ = 1'b1;
      end
      13'b1_1100_????_????:
      begin
        res = lit;
        wrA = 1'b1;
        pop = 1'b1;
      end
      13'b1_1101_????_????:
      begin
        res = diffK[7:0];
        wrA = 1'b1;
        {updZ, updC, updDC} = 3'h7;
        cOut = ~diffK[8];
        dcOut = lit[3:0] >= acc[3:0];
      end
      13'b1_1111_????_????:
      begin
        res = sumK[7:0];
        wrA = 1'b1;
        {updZ, updC, updDC} = 3'h7;
        cOut = sumK[8];
        dcOut = ({1'b0, lit[3:0]} + {1'b0, acc[3:0]}) > 5'h0F;
      end
      13'b0_1???_????_????:
      begin
        case (instrWord[10:9])
          2'h0:
          begin
            res = regVal & ~bitMask;
            wrR = 1'b1;
          end
          2'h1:
          begin
            res = regVal | bitMask;
            wrR = 1'b1;
          end
          2'h2:    skipTaken = (regVal & bitMask) == 8'h00;
          default: skipTaken = (regVal & bitMask) != 8'h00;
        endcase
      end
      13'h0000: ;
      13'h0001:
      begin
        res = daaTmp[7:0];
        cOut = 1'b0;
        if ((daaTmp[7:4] > 4'h9) || status[`RID_ST_C] || daaTmp[8])
        begin
          res = daaTmp[7:0] + 8'h60;
          cOut = 1'b1;
        end
        wrA = 1'b1;
        updC = 1'b1;
      end
      13'h0002: doCont = 1'b1;
      13'h0003: doSleep = 1'b1;
      13'h0004: doWdt = 1'b1;
      13'b0_0000_0000_????: iocWr = 1'b1;
      13'h0010: doEni = 1'b1;
      13'h0011: doDisi = 1'b1;
      13'h0012: pop = 1'b1;
      13'h0013:
      begin
        pop = 1'b1;
        doReti = 1'b1;
      end
      13'h0014:
      begin
        res = contReg;
        wrA = 1'b1;
      end
      13'b0_0000_0001_????:
      begin
        res = ioc[instrWord[3:0]];
        wrA = 1'b1;
        iocRd = 1'b1;
      end
      13'h0020:
      begin
        // Operand is the counter as read, not the register at the field
        res = pcPlus1[7:0] + acc;
        ea = `RID_A_PC;
        wrR = 1'b1;
        {updZ, updC, updDC} = 3'h7;
        cOut = ({1'b0, pcPlus1[7:0]} + {1'b0, acc}) > 9'h0FF;
        dcOut = ({1'b0, pcPlus1[3:0]} + {1'b0, acc[3:0]}) > 5'h0F;
      end
      13'b0_0000_01??_????:
      begin
        res = acc;
        wrR = 1'b1;
      end
      13'h0080:
      begin
        wrA = 1'b1;
        updZ = 1'b1;
      end
      13'b0_0000_11??_????:
      begin
        wrR = 1'b1;
        updZ = 1'b1;
      end
      13'b0_0???_????_????:
      begin
        wrR = instrWord[6];
        wrA = ~instrWord[6];
        updZ = 1'b1;
        case (instrWord[11:7])
          5'h02:
          begin
            res = diffR[7:0];
            {updC, updDC} = 2'h3;
            cOut = ~diffR[8];
            dcOut = regVal[3:0] >= acc[3:0];
          end
          5'h03: res = regVal - 8'h01;
          5'h04: res = regVal | acc;
          5'h05: res = regVal & acc;
          5'h06: res = regVal ^ acc;
          5'h07:
          begin
            res = sumR[7:0];
            {updC, updDC} = 2'h3;
            cOut = sumR[8];
            dcOut = ({1'b0, regVal[3:0]} + {1'b0, acc[3:0]}) > 5'h0F;
          end
          5'h08: res = regVal;
          5'h09: res = ~regVal;
          5'h0A: res = regVal + 8'h01;
          5'h0B:
          begin
            res = regVal - 8'h01;
            updZ = 1'b0;
            skipTaken = (res == 8'h00);
          end
          5'h0C:
          begin
            res = {status[`RID_ST_C], regVal[7:1]};
            updZ = 1'b0;
            updC = 1'b1;
            cOut = regVal[0];
          end
          5'h0D:
          begin
            res = {regVal[6:0], status[`RID_ST_C]};
            updZ = 1'b0;
            updC = 1'b1;
            cOut = regVal[7];
          end
          5'h0E:
          begin
            res = {regVal[3:0], regVal[7:4]};
            updZ = 1'b0;
          end
          5'h0F:
          begin
            res = regVal + 8'h01;
            updZ = 1'b0;
            skipTaken = (res == 8'h00);
          end
          default:
          begin
            wrR = 1'b0;
            wrA = 1'b0;
            updZ = 1'b0;
          end
        endcase
      end
      default: ;
    endcase
    pcWr = wrR && (ea == `RID_A_PC);
    next_status = (wrR && ea == `RID_A_STATUS) ? res : status;
    if (updZ)
      next_status[`RID_ST_Z] = (res == 8'h00);
    if (updC)
      next_status[`RID_ST_C] = cOut;
    if (updDC)
      next_status[`RID_ST_DC] = dcOut;
    if (doSleep)
      {next_status[`RID_ST_T], next_status[`RID_ST_P]} = 2'h2;
    if (doWdt)
      {next_status[`RID_ST_T], next_status[`RID_ST_P]} = 2'h3;
  end

  // Next counter; the fetch address follows it at once, so the operand
  // address set on the next phase-0 edge belongs to the new instruction
  always @*
  begin
    if (pop)
      next_pc = stack[sp - 3'h1];
    else if (jump)
      next_pc = target;
    else if (pcWr)
      next_pc = {pc[12:8], res};
    else if (skipTaken)
      next_pc = pc + 13'h0002;
    else
      next_pc = pcPlus1;
  end

  // Option capture and start-up wait
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      optWordZero <= 13'h0000;
      optWordOne  <= 13'h0000;
      optLoaded   <= 1'b0;
      waitCnt     <= {`RID_WAIT_W{1'b0}};
      coreRunning <= 1'b0;
    end
    else if (!optLoaded)
    begin
      // option words load only from the strap inputs
      optWordZero <= optWordZeroIn;
      optWordOne  <= optWordOneIn;
      optLoaded   <= 1'b1;
    end
    else if (!coreRunning)
    begin
      if (waitCnt >= waitLimit - 1'b1)
        coreRunning <= 1'b1;
      else
        waitCnt <= waitCnt + 1'b1;
    end
  end

  always @*
  begin
    case (optWordZero[`RID_OPT0_OST_HI:`RID_OPT0_OST_LO])
      2'h0:    waitLimit = WAIT0_CYCLES[`RID_WAIT_W-1:0];
      2'h1:    waitLimit = WAIT1_CYCLES[`RID_WAIT_W-1:0];
      2'h2:    waitLimit = WAIT2_CYCLES[`RID_WAIT_W-1:0];
      default: waitLimit = WAIT3_CYCLES[`RID_WAIT_W-1:0];
    endcase
  end

  // Option outputs
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      coreSlowClock        <= 1'b0;
      pullUpConnect        <= 1'b0;
      endpointTwoOn        <= 1'b0;
      endpointTwoDirection <= 1'b0;
      endpointTwoMaxBytes  <= 4'h0;
      packageCode          <= 2'h0;
      packageKnown         <= 1'b0;
    end
    else
    begin
      coreSlowClock        <= optWordZero[`RID_OPT0_FREQ];
      pullUpConnect        <= optLoaded & ~optWordOne[`RID_OPT1_PULLUP];
      endpointTwoOn        <= optWordOne[`RID_OPT1_EP2_ON];
      endpointTwoDirection <= optWordOne[`RID_OPT1_ENDPOINT_TWO_DIRECTION];
      endpointTwoMaxBytes  <= {1'b0, optWordOne[`RID_OPT1_EP2_MAX_HI:
                              `RID_OPT1_EP2_MAX_LO]} + 4'h1;
      packageCode  <= optWordOne[`RID_OPT1_PKG_HI:`RID_OPT1_PKG_LO];
      packageKnown <= (optWordOne[`RID_OPT1_PKG_HI:`RID_OPT1_PKG_LO] ==
                       `RID_PKG_40) ||
                      (optWordOne[`RID_OPT1_PKG_HI:`RID_OPT1_PKG_LO] ==
                       `RID_PKG_44);
    end
  end

  // Execution state
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase      <= 1'b0;
      bubble     <= 1'b0;
      pc         <= 13'h0000;
      romAddr    <= 13'h0000;
      acc        <= 8'h00;
      status     <= `RID_STATUS_RESET;
      bankSel    <= 8'h00;
      timerReg   <= 8'h00;
      sp         <= 3'h0;
      irqEnable  <= 1'b0;
      contReg    <= `RID_CONT_RESET;
      ioAddr     <= 4'h0;
      ioWrite    <= 1'b0;
      ioWdata    <= 8'h00;
      wdtClear   <= 1'b0;
      sleepStart <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
        ioc[i] <= `RID_IOC_RESET;
    end
    else
    begin
      ioWrite    <= 1'b0;
      wdtClear   <= 1'b0;
      sleepStart <= 1'b0;
      if (run)
        phase <= ~phase;
      if (run && !phase)
        ioAddr <= ea[3:0];
      if (exec && bubble)
        bubble <= 1'b0;
      else if (exec)
      begin
        // counter changes cost a second cycle
        bubble  <= jump | pop | pcWr | skipTaken;
        pc      <= next_pc;
        romAddr <= next_pc;
        if (push)
          sp <= sp + 3'h1;
        else if (pop)
          sp <= sp - 3'h1;
        if (wrA)
          acc <= res;
        status <= next_status;
        if (wrR && ea == `RID_A_BANK)
          bankSel <= res;
        if (wrR && ea == `RID_A_TIMER)
          timerReg <= res;
        if (wrR && ea >= `RID_A_IO_FIRST && ea < `RID_A_GPR_FIRST)
        begin
          ioWrite <= 1'b1;
          ioWdata <= res;
        end
        if (iocWr)
          ioc[instrWord[3:0]] <= acc;
        if (doCont)
          contReg <= acc;
        if (doEni || doReti)
          irqEnable <= 1'b1;
        else if (doDisi)
          irqEnable <= 1'b0;
        wdtClear   <= doWdt | doSleep;
        sleepStart <= doSleep;
      end
    end
  end

  // Register and stack storage
  always @(posedge clk)
  begin
    if (exec && !bubble && wrR && ea >= `RID_A_GPR_FIRST)
      gpr[{bankSel[`RID_BANK_HI:`RID_BANK_LO], ea}] <= res;
    if (exec && !bubble && push)
      stack[sp] <= pcPlus1;
  end

  // Register port
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      runEnable <= `RID_CTRL_RESET;
      regRdata  <= 13'h0000;
    end
    else
    begin
      if (regWrite && regAddr == `RID_REG_CTRL)
        runEnable <= regWdata[`RID_CTRL_RUN];
      regRdata <= 13'h0000;
      if (regRead)
      begin
        case (regAddr)
          `RID_REG_OPT0: regRdata <= optWordZero;
          `RID_REG_OPT1: regRdata <= optWordOne;
          `RID_REG_CTRL: regRdata <= {12'h000, runEnable};
          `RID_REG_PC:   regRdata <= pc;
          `RID_REG_ACC:  regRdata <= {2'h0, next_status[2:0], acc};
          default:       regRdata <= 13'h0000;
        endcase
      end
    end
  end

endmodule

//--- sim/rid_core_checker.sv
`timescale 1ns/100ps
module rid_core_checker #(
  parameter WAIT0_CYCLES = 5,
  parameter WAIT1_CYCLES = 6,
  parameter WAIT2_CYCLES = 7,
  parameter WAIT3_CYCLES = 8
) (
  // Clock and reset
  input logic        clk,
  input logic        arst_n,
  // Option straps and decoded options
  input logic [12:0] optWordZeroIn,
  input logic [12:0] optWordOneIn,
  input logic        coreSlowClock,
  input logic        pullUpConnect,
  input logic        endpointTwoOn,
  input logic        endpointTwoDirection,
  input logic [3:0]  endpointTwoMaxBytes,
  input logic [1:0]  packageCode,
  input logic        packageKnown,
  // Core activity
  input logic        ioWrite,
  input logic        adcBusy,
  input logic        coreRunning,
  // Register port
  input logic [3:0]  regAddr,
  input logic        regRead,
  input logic [12:0] regRdata
);
  logic [1:0]  sinceRst;
  logic [20:0] edgeCnt;
  int          waitLen;
  logic        live;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Edges since release; decoded options settle after the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sinceRst <= 2'h0;
      edgeCnt  <= 21'h000000;
    end
    else
    begin
      sinceRst <= (sinceRst == 2'h3) ? sinceRst : sinceRst + 2'h1;
      edgeCnt  <= (edgeCnt == 21'h1FFFFF) ? edgeCnt : edgeCnt + 21'h000001;
    end
  end

  assign live = (sinceRst == 2'h3);

  always_comb
  begin
    case (optWordZeroIn[3:2])
      2'h0:    waitLen = WAIT0_CYCLES;
      2'h1:    waitLen = WAIT1_CYCLES;
      2'h2:    waitLen = WAIT2_CYCLES;
      default: waitLen = WAIT3_CYCLES;
    endcase
  end

  sequence optZeroRead;
    regRead && regAddr == 4'h0;
  endsequence

  sequence noRead;
    !regRead;
  endsequence

  clock_select_a:
    assert property (live |-> coreSlowClock == optWordZeroIn[1])
    else $error("Core clock select wrong");
  pullup_switch_a:
    assert property (live |-> pullUpConnect == !optWordOneIn[4])
    else $error("Pull-up switch wrong");
  endpoint_mode_a:
    assert property (live |-> endpointTwoOn == optWordOneIn[6]
      && endpointTwoDirection == optWordOneIn[7])
    else $error("Endpoint two mode wrong");
  endpoint_size_a:
    assert property (live |->
      endpointTwoMaxBytes == {1'b0, optWordOneIn[10:8]} + 4'h1)
    else $error("Endpoint two size wrong");
  package_code_a:
    assert property (live |-> packageCode == optWordOneIn[1:0]
      && packageKnown == optWordOneIn[0])
    else $error("Package code wrong");
  write_spacing_a:
    assert property (ioWrite |=> !ioWrite)
    else $error("I/O writes closer than one instruction");
  conversion_hold_a:
    assert property (live && !optWordOneIn[5] && adcBusy |=> !ioWrite)
    else $error("Core ran during conversion hold");
  startup_wait_a:
    assert property ($rose(coreRunning) |-> edgeCnt == waitLen + 1)
    else $error("Start-up wait length wrong");
  option_read_a:
    assert property (optZeroRead |=> regRdata == optWordZeroIn)
    else $error("Option word zero read wrong");
  read_idle_a:
    assert property (noRead |=> regRdata == 13'h0000)
    else $error("Read data outside read slot");
endmodule

bind rid_core rid_core_checker #(
  .WAIT0_CYCLES(WAIT0_CYCLES),
  .WAIT1_CYCLES(WAIT1_CYCLES),
  .WAIT2_CYCLES(WAIT2_CYCLES),
  .WAIT3_CYCLES(WAIT3_CYCLES)
) checkerInst (
  .clk, .arst_n, .optWordZeroIn, .optWordOneIn, .coreSlowClock,
  .pullUpConnect, .endpointTwoOn, .endpointTwoDirection,
  .endpointTwoMaxBytes, .packageCode, .packageKnown, .ioWrite, .adcBusy,
  .coreRunning, .regAddr, .regRead, .regRdata
);

//--- sim/rid_rom.sv
`timescale 1ns/100ps
module rid_rom (
  // Fetch port
  input  logic [12:0] romAddr,
  output logic [12:0] instrWord,
  // Program fields
  input  logic [7:0]  litVal,
  input  logic [2:0]  setBit,
  input  logic [2:0]  clrBit
);
  // Words 5-7 and 10 must never execute: they write I/O register 8
  always_comb
  begin
    case (romAddr)
      13'h0000: instrWord = {5'h18, litVal};
      13'h0001: instrWord = 13'h0045;
      13'h0002: instrWord = {4'h5, setBit, 6'h06};
      13'h0003: instrWord = {4'h4, clrBit, 6'h07};
      13'h0004: instrWord = 13'h1408;
      13'h0008: instrWord = 13'h0049;
      13'h0009: instrWord = 13'h05CA;
      13'h000B: instrWord = 13'h004C;
      13'h000C: instrWord = 13'h000D;
      13'h000D: instrWord = 13'h1E55;
      13'h000E: instrWord = 13'h004D;
      13'h000F: instrWord = 13'h140F;
      default:  instrWord = 13'h0048;
    endcase
  end
endmodule

//--- sim/risc_instruction_decode_and_options_bench.sv
`timescale 1ns/100ps
module risc_instruction_decode_and_options_bench;
  logic         clk, arst_n, ioWrite, adcBusy, coreRunning, regWrite;
  logic         regRead, rdLate, slowClk, pullUp, epOn, epDir, pkgKnown;
  logic [12:0]  optZero, optOne, romAddr, instrWord, regWdata, regRdata;
  logic [3:0]   ioAddr, regAddr, epMax, u;
  logic [7:0]   ioWdata, ioRdata, rdVal, litVal;
  logic [2:0]   setBit, clrBit;
  logic [1:0]   pkgCode;
  logic [127:0] ioCtl;
  logic [15:0]  ioExp;
  logic [31:0]  rs = 32'hF535;
  int           failCount, compares, cyc, lastIo;
  logic [15:0]  ioQ[$];
  logic [12:0]  regQ[$];

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  rid_core #(
    .WAIT0_CYCLES(5), .WAIT1_CYCLES(6), .WAIT2_CYCLES(7), .WAIT3_CYCLES(8)
  ) DUT (
    .clk, .arst_n, .optWordZeroIn(optZero), .optWordOneIn(optOne), .romAddr,
    .instrWord, .ioAddr, .ioWrite, .ioWdata, .ioRdata, .adcBusy, .coreRunning,
    .irqEnable(), .contReg(), .ioControlFlat(ioCtl), .wdtClear(),
    .sleepStart(), .coreSlowClock(slowClk), .pullUpConnect(pullUp),
    .endpointTwoOn(epOn), .endpointTwoDirection(epDir),
    .endpointTwoMaxBytes(epMax), .packageCode(pkgCode),
    .packageKnown(pkgKnown), .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata
  );

  rid_rom rom (.romAddr, .instrWord, .litVal, .setBit, .clrBit);

  // Peripheral read data; register 0x0A reads 1 so the decrement hits zero
  assign ioRdata = (ioAddr == 4'hA) ? 8'h01 : rdVal;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string what, input logic [12:0] e,
                     input logic [12:0] s);
    compares++;
    if (e !== s)
    begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic results;
    $display("Compares %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One bus cycle; for a read, d is the expected data
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [12:0] d);
    if (!wr)
      regQ.push_back(d);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= wr;
    regRead  <= !wr;
    @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    rs = xs(rs);
    adcBusy <= rs[0];
    rdLate  <= regRead;
    cyc++;
    if (cyc == 5000)
    begin
      failCount++;
      results();
    end
  end

  always @(negedge clk)
  begin
    if (rdLate === 1'b1)
      chk("read data", regQ.pop_front(), regRdata);
    if (ioWrite === 1'b1)
    begin
      ioExp = (ioQ.size() > 0) ? ioQ.pop_front() : 16'hFFFF;
      chk("io address", ioExp[15:12], ioAddr);
      chk("io data", ioExp[11:4], ioWdata);
      if (ioExp[3:0] != 4'h0)
        chk("io spacing", ioExp[3:0], 13'(cyc - lastIo));
      lastIo = cyc;
    end
  end

  initial
  begin
    int n;
    arst_n = 1'b0;
    {optZero, optOne, regWdata} = '0;
    {regAddr, regWrite, regRead, adcBusy, rdLate} = '0;
    {litVal, setBit, clrBit, rdVal} = '0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      arst_n  <= 1'b0;
      optZero <= (rs[12:0] & 13'h1FF3) | 13'(i << 2);
      optOne  <= (rs[25:13] & 13'h07D0) | 13'(i) | 13'(i[0] << 5);
      @(posedge clk);
      litVal <= rs[7:0];
      setBit <= rs[10:8];
      clrBit <= rs[13:11];
      rdVal  <= rs[21:14];
      repeat (19) @(posedge clk);
      u = optOne[5] ? 4'h1 : 4'h0;
      ioQ.push_back({4'h5, litVal, 4'h0});
      ioQ.push_back({4'h6, rdVal | (8'h01 << setBit), 4'h2 * u});
      ioQ.push_back({4'h7, rdVal & ~(8'h01 << clrBit), 4'h2 * u});
      ioQ.push_back({4'h9, litVal, 4'h6 * u});
      ioQ.push_back({4'hA, 8'h00, 4'h2 * u});
      ioQ.push_back({4'hC, litVal, 4'h4 * u});
      ioQ.push_back({4'hD, litVal, 4'h6 * u});
      arst_n <= 1'b1;
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (coreRunning !== 1'b1 && n < 40);
      chk("start-up edges", 13'(7 + i), 13'(n));
      chk("slow clock", optZero[1], slowClk);
      chk("pull-up", !optOne[4], pullUp);
      chk("endpoint on", optOne[6], epOn);
      chk("endpoint dir", optOne[7], epDir);
      chk("endpoint size", optOne[10:8] + 4'h1, epMax);
      chk("package", optOne[1:0], pkgCode);
      chk("package known", optOne[0], pkgKnown);
      @(posedge clk);
      bus(1'b1, 4'h0, ~optZero);
      bus(1'b1, 4'h1, ~optOne);
      bus(1'b0, 4'h0, optZero);
      bus(1'b0, 4'h1, optOne);
      bus(1'b0, 4'h9, 13'h0000);
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      n = 0;
      while (ioQ.size() > 0 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      chk("writes left", 13'h0000, 13'(ioQ.size()));
      repeat (8) @(negedge clk);
      chk("control reg", litVal, ioCtl[104 +: 8]);
    end
    results();
  end
endmodule
